//--- verilog/vic_defs.svh
// constants for the vectored interrupt unit: offsets, fields, resets
// assumes byte addresses on a 12-bit register port, one word per register
// Function
// - each non-fast source has a 3-bit priority, 0 lowest, 7 highest
// - source 0 is the fast source; arbitration ignores its priority
// - internal sources: type low bit 0 high level, 1 rising edge
// - external: 00 low level, 01 falling, 10 high level, 11 rising
// - thirty-two read/write 32-bit handler vector registers, one per source
// - normal vector read returns the vector of the selected current source
// - no normal interrupt current: normal vector read returns spurious vector
// - fast vector read returns the vector stored for source 0
// - no fast interrupt active: fast vector read returns spurious vector
// - status register low five bits give the source being serviced
// - pending register shows one bit per pending source
// - enable register shows one bit per enabled source
// - core status: bit 0 fast line active, bit 1 normal line active
// - enable command: written ones enable sources, zeros change nothing
// - normal mode vector read records, pushes priority and acknowledges
// - protect mode: push and acknowledge only on vector register write
// - any write to end-of-interrupt register ends current treatment
// - general mask bit set holds both core request lines inactive
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define SMR_BASE 12'h000
`define SVR_BASE 12'h080
`define IVR_OFF 12'h100
`define FVR_OFF 12'h104
`define ISR_OFF 12'h108
`define IPR_OFF 12'h10c
`define IMR_OFF 12'h110
`define CISR_OFF 12'h114
`define IECR_OFF 12'h120
`define IDCR_OFF 12'h124
`define EOICR_OFF 12'h130
`define SPU_OFF 12'h134
`define DCR_OFF 12'h138
`define EVT_STAT_OFF 12'h150
`define EVT_MASK_OFF 12'h154

`define PRIO_LSB 0
`define TRIG_LSB 5
`define DCR_PROT_BIT 0
`define DCR_MASK_BIT 1
`define EVT_SPUR_NORM 0
`define EVT_EOI_EMPTY 1
`define EVT_SPUR_FAST 2

`define REG_RESET 32'h0000_0000
`define EXT_SOURCES 32'hc000_0001
`define STACK_DEPTH 4'h8

`endif

//--- verilog/vic_pkg.sv
// types shared by the vectored interrupt unit
// assumes vic_defs.svh holds the numeric constants
package vic_pkg;
    typedef struct packed {
        logic [1:0] trigger_type;
        logic [2:0] priority_level;
    } mode_type;

    typedef struct packed {
        logic [4:0] src;
        logic [2:0] pri;
    } frame_type;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
endpackage

//--- verilog/vectored_irq_unit.sv
// vectored interrupt unit: 32 sources, 8-level priority stack, core lines
// assumes synchronous sources, one clock, a never-waiting register master
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defs.svh"

module vectored_irq_unit (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // register port
    input wire vic_pkg::bus_req_type bus_in,
    output logic [31:0] rdata_out,
    // interrupt sources
    input wire logic [31:0] source_in,
    // core request lines, active low
    output logic normal_request_line_n_out,
    output logic fast_request_line_n_out,
    // event interrupt
    output logic irq_out
);
    import vic_pkg::*;

    mode_type mode_ff [32];
    logic [31:0] vector_ff [32];
    logic [31:0] spu_ff;
    logic [1:0] dcr_ff;
    logic [31:0] enable_ff;
    logic [31:0] latch_ff;
    logic [31:0] prev_ff;
    logic [31:0] active;
    logic [31:0] pending;
    frame_type cur_ff;
    frame_type stack_ff [8];
    logic [3:0] depth_ff;
    frame_type held_ff;
    logic held_valid_ff;
    logic [2:0] evt_ff;
    logic [2:0] evt_mask_ff;
    logic [31:0] rdata_ff;
    logic normal_line_n_ff;
    logic fast_line_n_ff;
    logic irq_ff;

    logic rd_ivr, wr_ivr, rd_fvr, wr_eoi;
    logic win_valid;
    frame_type win;
    logic fast_act;
    logic push;
    frame_type push_frame;
    logic pop;
    logic [31:0] ack_clr;
    logic [2:0] evt_set;
    logic [31:0] nxt_rdata;

    assign rd_ivr = ce_in && bus_in.rd && bus_in.addr == `IVR_OFF;
    assign wr_ivr = ce_in && bus_in.wr && bus_in.addr == `IVR_OFF;
    assign rd_fvr = ce_in && bus_in.rd && bus_in.addr == `FVR_OFF;
    assign wr_eoi = ce_in && bus_in.wr && bus_in.addr == `EOICR_OFF;

    // per-source trigger decode and edge latch
    for (genvar i = 0; i < 32; i++) begin : g_src
        logic ext;
        assign ext = 1'(`EXT_SOURCES >> i);
        // invert only for external sources with type high bit clear
        assign active[i] = source_in[i]
            ^ (ext & ~mode_ff[i].trigger_type[1]);
        assign pending[i] = mode_ff[i].trigger_type[0]
            ? latch_ff[i] : active[i];
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                prev_ff[i] <= 1'b0;
                latch_ff[i] <= 1'b0;
            end else if (ce_in) begin
                prev_ff[i] <= active[i];
                // set wins over acknowledge; level mode holds the latch
                // clear so a stale edge cannot surface after a mode switch
                if (mode_ff[i].trigger_type[0]
                    && active[i] && !prev_ff[i]) begin
                    latch_ff[i] <= 1'b1;
                end else if (ack_clr[i]
                             || !mode_ff[i].trigger_type[0]) begin
                    latch_ff[i] <= 1'b0;
                end
            end
        end
        edge_latch_a: assert property (@(posedge clock_in)
            disable iff (!rst_n_in) ce_in && mode_ff[i].trigger_type[0]
            && active[i] && !prev_ff[i] |=> latch_ff[i])
            else $error("edge not latched");
        level_clear_a: assert property (@(posedge clock_in)
            disable iff (!rst_n_in)
            ce_in && !mode_ff[i].trigger_type[0] |=> !latch_ff[i])
            else $error("latch set in level mode");
    end

    // arbitration over sources 1..31; ties go to the lowest number
    always_comb begin
        win_valid = 1'b0;
        win = '0;
        for (int i = 1; i < 32; i++) begin
            if (pending[i] && enable_ff[i]
                && (depth_ff == 4'h0
                    || mode_ff[i].priority_level > cur_ff.pri)
                && (!win_valid
                    || mode_ff[i].priority_level > win.pri)) begin
                win_valid = 1'b1;
                win.src = 5'(i);
                win.pri = mode_ff[i].priority_level;
            end
        end
    end

    assign fast_act = pending[0] && enable_ff[0];

    // push on read in normal mode, on write of the held one in protect mode
    always_comb begin
        push = 1'b0;
        push_frame = win;
        ack_clr = '0;
        if (rd_ivr && win_valid && !dcr_ff[`DCR_PROT_BIT]) begin
            push = depth_ff != `STACK_DEPTH;
        end else if (wr_ivr && held_valid_ff
                     && dcr_ff[`DCR_PROT_BIT]) begin
            push = depth_ff != `STACK_DEPTH;
            push_frame = held_ff;
        end
        if (push) begin
            ack_clr[push_frame.src] = 1'b1;
        end
        if (rd_fvr) begin
            ack_clr[0] = 1'b1;
        end
    end

    assign pop = wr_eoi && depth_ff != 4'h0;

    // priority stack
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_ff <= '0;
            depth_ff <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                stack_ff[i] <= '0;
            end
        end else if (ce_in) begin
            if (push) begin
                if (depth_ff != 4'h0) begin
                    stack_ff[depth_ff[2:0] - 3'h1] <= cur_ff;
                end
                cur_ff <= push_frame;
                depth_ff <= depth_ff + 4'h1;
            end else if (pop) begin
                if (depth_ff > 4'h1) begin
                    cur_ff <= stack_ff[depth_ff[2:0] - 3'h2];
                end
                depth_ff <= depth_ff - 4'h1;
            end
        end
    end

    // protect mode: a read only memorises the winner
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_ff <= '0;
            held_valid_ff <= 1'b0;
        end else if (ce_in) begin
            if (rd_ivr && dcr_ff[`DCR_PROT_BIT]) begin
                held_ff <= win;
                held_valid_ff <= win_valid;
            end else if (wr_ivr) begin
                held_valid_ff <= 1'b0;
            end
        end
    end

    // software-written registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spu_ff <= `REG_RESET;
            dcr_ff <= 2'h0;
            enable_ff <= `REG_RESET;
            evt_mask_ff <= 3'h0;
            for (int i = 0; i < 32; i++) begin
                mode_ff[i] <= '0;
                vector_ff[i] <= `REG_RESET;
            end
        end else if (ce_in && bus_in.wr) begin
            if (bus_in.addr[11:7] == `SMR_BASE >> 7) begin
                mode_ff[bus_in.addr[6:2]].trigger_type <=
                    bus_in.wdata[`TRIG_LSB +: 2];
                mode_ff[bus_in.addr[6:2]].priority_level <=
                    bus_in.wdata[`PRIO_LSB +: 3];
            end else if (bus_in.addr[11:7] == `SVR_BASE >> 7) begin
                vector_ff[bus_in.addr[6:2]] <= bus_in.wdata;
            end
            case (bus_in.addr)
                `IECR_OFF: enable_ff <= enable_ff | bus_in.wdata;
                `IDCR_OFF: enable_ff <= enable_ff & ~bus_in.wdata;
                `SPU_OFF: spu_ff <= bus_in.wdata;
                `DCR_OFF: dcr_ff <= bus_in.wdata[1:0];
                `EVT_MASK_OFF: evt_mask_ff <= bus_in.wdata[2:0];
                default: ;
            endcase
        end
    end

    // read mux, data valid in the cycle after the strobe
    always_comb begin
        nxt_rdata = '0;
        if (bus_in.addr[11:7] == `SMR_BASE >> 7) begin
            nxt_rdata[`TRIG_LSB +: 2] = mode_ff[bus_in.addr[6:2]].trigger_type;
            nxt_rdata[`PRIO_LSB +: 3] =
                mode_ff[bus_in.addr[6:2]].priority_level;
        end else if (bus_in.addr[11:7] == `SVR_BASE >> 7) begin
            nxt_rdata = vector_ff[bus_in.addr[6:2]];
        end else begin
            case (bus_in.addr)
                `IVR_OFF: nxt_rdata = win_valid
                    ? vector_ff[win.src] : spu_ff;
                `FVR_OFF: nxt_rdata = fast_act
                    ? vector_ff[0] : spu_ff;
                `ISR_OFF: nxt_rdata[4:0] = cur_ff.src;
                `IPR_OFF: nxt_rdata = pending;
                `IMR_OFF: nxt_rdata = enable_ff;
                `CISR_OFF: nxt_rdata[1:0] =
                    {~normal_line_n_ff, ~fast_line_n_ff};
                `SPU_OFF: nxt_rdata = spu_ff;
                `DCR_OFF: nxt_rdata[1:0] = dcr_ff;
                `EVT_STAT_OFF: nxt_rdata[2:0] = evt_ff;
                `EVT_MASK_OFF: nxt_rdata[2:0] = evt_mask_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= `REG_RESET;
        end else if (ce_in) begin
            rdata_ff <= bus_in.rd ? nxt_rdata : `REG_RESET;
        end
    end

    // core lines, registered; mask wins over any request
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            normal_line_n_ff <= 1'b1;
            fast_line_n_ff <= 1'b1;
        end else if (ce_in) begin
            normal_line_n_ff <= !(win_valid && !dcr_ff[`DCR_MASK_BIT]);
            fast_line_n_ff <= !(fast_act && !dcr_ff[`DCR_MASK_BIT]);
        end
    end

    // sticky events; a read clears them but a same-cycle set survives
    assign evt_set[`EVT_SPUR_NORM] = rd_ivr && !win_valid;
    assign evt_set[`EVT_EOI_EMPTY] = wr_eoi && depth_ff == 4'h0;
    assign evt_set[`EVT_SPUR_FAST] = rd_fvr && !fast_act;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else if (ce_in) begin
            if (bus_in.rd && bus_in.addr == `EVT_STAT_OFF) begin
                evt_ff <= evt_set;
            end else begin
                evt_ff <= evt_ff | evt_set;
            end
            irq_ff <= |(evt_ff & evt_mask_ff);
        end
    end

    assign rdata_out = rdata_ff;
    assign normal_request_line_n_out = normal_line_n_ff;
    assign fast_request_line_n_out = fast_line_n_ff;
    assign irq_out = irq_ff;

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence ivr_read_prot_s;
        rd_ivr && dcr_ff[`DCR_PROT_BIT] && win_valid
            && depth_ff != `STACK_DEPTH;
    endsequence
    sequence ivr_write_s;
        wr_ivr && dcr_ff[`DCR_PROT_BIT] && held_valid_ff
            && depth_ff != `STACK_DEPTH;
    endsequence

    gmask_lines_a: assert property (ce_in && dcr_ff[`DCR_MASK_BIT]
        |=> normal_request_line_n_out && fast_request_line_n_out)
        else $error("request line active under general mask");
    fast_exclude_a: assert property (win_valid |-> win.src != 5'h0)
        else $error("fast source entered normal arbitration");
    prio_order_a: assert property (win_valid && depth_ff != 4'h0
        |-> win.pri > cur_ff.pri)
        else $error("winner not above current priority");
    norm_vector_a: assert property (rd_ivr && win_valid
        |=> rdata_out == $past(vector_ff[win.src]))
        else $error("normal vector not from current source");
    norm_spur_a: assert property (rd_ivr && !win_valid
        |=> rdata_out == $past(spu_ff))
        else $error("spurious vector missing on normal read");
    fast_vector_a: assert property (rd_fvr && fast_act
        |=> rdata_out == $past(vector_ff[0]))
        else $error("fast vector not source 0");
    fast_spur_a: assert property (rd_fvr && !fast_act
        |=> rdata_out == $past(spu_ff))
        else $error("spurious vector missing on fast read");
    status_num_a: assert property (ce_in && bus_in.rd
        && bus_in.addr == `ISR_OFF |=> rdata_out[4:0] == $past(cur_ff.src))
        else $error("status number wrong");
    normal_push_a: assert property (rd_ivr && win_valid
        && !dcr_ff[`DCR_PROT_BIT] && depth_ff != `STACK_DEPTH
        |=> depth_ff == $past(depth_ff) + 4'h1 && cur_ff == $past(win))
        else $error("normal read did not push");
    protect_read_a: assert property (ivr_read_prot_s
        |=> depth_ff == $past(depth_ff))
        else $error("protect read changed stack");
    protect_write_a: assert property (ivr_write_s
        |=> depth_ff == $past(depth_ff) + 4'h1 && cur_ff == $past(held_ff))
        else $error("protect write did not push");
    eoi_pop_a: assert property (wr_eoi && depth_ff != 4'h0
        |=> depth_ff == $past(depth_ff) - 4'h1)
        else $error("end of interrupt did not pop");
    enable_cmd_a: assert property (ce_in && bus_in.wr
        && bus_in.addr == `IECR_OFF
        |=> enable_ff == ($past(enable_ff) | $past(bus_in.wdata)))
        else $error("enable command wrong");
    disable_cmd_a: assert property (ce_in && bus_in.wr
        && bus_in.addr == `IDCR_OFF
        |=> enable_ff == ($past(enable_ff) & ~$past(bus_in.wdata)))
        else $error("disable command wrong");
    core_status_a: assert property (ce_in && bus_in.rd
        && bus_in.addr == `CISR_OFF |=> rdata_out[1:0]
        == {~$past(normal_line_n_ff), ~$past(fast_line_n_ff)})
        else $error("core status wrong");

    depth_bound_a: assert property (depth_ff <= `STACK_DEPTH)
        else $error("stack depth beyond limit");
    held_clear_a: assert property (wr_ivr |=> !held_valid_ff)
        else $error("held winner kept after vector write");
    eoi_empty_a: assert property (wr_eoi && depth_ff == 4'h0
        |=> evt_ff[`EVT_EOI_EMPTY])
        else $error("empty end of interrupt not flagged");
    spur_event_a: assert property (rd_ivr && !win_valid
        |=> evt_ff[`EVT_SPUR_NORM])
        else $error("spurious normal read not flagged");
    evt_clear_a: assert property (ce_in && bus_in.rd
        && bus_in.addr == `EVT_STAT_OFF |=> evt_ff == $past(evt_set))
        else $error("event status not cleared by read");
    irq_level_a: assert property (ce_in && |(evt_ff & evt_mask_ff)
        |=> irq_out)
        else $error("event interrupt missing");
    rdata_idle_a: assert property (ce_in && !bus_in.rd
        |=> rdata_out == 32'h0)
        else $error("read data not cleared");
    normal_line_a: assert property (ce_in && win_valid
        && !dcr_ff[`DCR_MASK_BIT] |=> !normal_request_line_n_out)
        else $error("normal line not driven active");
    fast_line_a: assert property (ce_in && fast_act
        && !dcr_ff[`DCR_MASK_BIT] |=> !fast_request_line_n_out)
        else $error("fast line not driven active");
    freeze_a: assert property (!ce_in
        |=> $stable(enable_ff) && $stable(depth_ff) && $stable(rdata_out))
        else $error("state moved with clock enable low");
endmodule

`default_nettype wire

//--- tb/core_model.sv
// core-side model: decodes the request lines, takes after a set delay
// assumes the unit's active-low lines and a single clock
`timescale 1ns/100ps
`default_nettype none

module core_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // lines from the unit, and handler latency
    input wire logic normal_request_line_n_in,
    input wire logic fast_request_line_n_in,
    input wire logic [3:0] delay_in,
    // decoded state
    output logic normal_active_out,
    output logic fast_active_out,
    output logic take_out
);
    logic [3:0] wait_ff;

    assign normal_active_out = ~normal_request_line_n_in;
    assign fast_active_out = ~fast_request_line_n_in;
    // zero delay is a prompt core, larger ones a slow handler entry
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in)
            wait_ff <= 4'h0;
        else if (!normal_active_out)
            wait_ff <= 4'h0;
        else if (wait_ff != 4'hf)
            wait_ff <= wait_ff + 4'h1;
    end
    assign take_out = normal_active_out && (wait_ff >= delay_in);
endmodule
`default_nettype wire

//--- tb/tb_vectored_irq_unit.sv
// self-checking bench for the vectored interrupt unit
// assumes the core model on the request lines, clock of 100 ns
`timescale 1ns/100ps
`default_nettype none
`include "vic_defs.svh"

module tb_vectored_irq_unit;
    import vic_pkg::*;
    typedef struct {
        logic [11:0] addr;
        logic [31:0] exp;
    } note_type;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    bus_req_type bus = '0;
    logic [31:0] src = 32'hc000_0001;
    logic [31:0] rdata;
    logic nrm_n, fst_n, irq, nrm_act, fst_act, take;
    logic rd_d = 1'b0;
    logic ce = 1'b1;
    logic [3:0] delay = 4'h0;
    logic [31:0] seed = 32'h25c9d0f2;
    logic [31:0] vec [32];
    logic [31:0] spur, w, en;
    logic [11:0] rst_regs [12] = '{`SMR_BASE, `SVR_BASE, `ISR_OFF,
        `IPR_OFF, `IMR_OFF, `CISR_OFF, `SPU_OFF, `DCR_OFF, `EVT_STAT_OFF,
        `EVT_MASK_OFF, 12'h118, `IECR_OFF};
    note_type notes [$];
    note_type n;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    vectored_irq_unit dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .bus_in(bus), .rdata_out(rdata), .source_in(src),
        .normal_request_line_n_out(nrm_n),
        .fast_request_line_n_out(fst_n), .irq_out(irq));
    core_model core (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .normal_request_line_n_in(nrm_n), .fast_request_line_n_in(fst_n),
        .delay_in(delay), .normal_active_out(nrm_act),
        .fast_active_out(fst_act), .take_out(take));

    always #50 clock_in = ~clock_in;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] ofs(input logic [11:0] b, input int s);
        return b + 12'(s * 4);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // requests are held until the next request or an idle replaces them
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        notes.push_back('{addr: a, exp: e});
        @(posedge clock_in);
    endtask

    task automatic idle(input int k);
        bus <= '0;
        repeat (k) @(posedge clock_in);
    endtask

    // outputs are looked at mid-cycle, away from the launching edge
    task automatic lines(input logic [2:0] e);
        idle(0);
        @(negedge clock_in);
        check("irq normal fast", 32'({irq, nrm_n, fst_n}), 32'(e));
        @(posedge clock_in);
    endtask

    task automatic service(input int s, input logic [3:0] dly,
                           input logic [31:0] mid, input logic rel);
        int k;
        idle(1);
        delay <= dly;
        for (k = 0; k < 40; k++) begin
            @(negedge clock_in);
            if (take === 1'b1)
                break;
        end
        @(posedge clock_in);
        check("core take", 32'(k < 40), 32'h1);
        rd(`IVR_OFF, vec[s]);
        rd(`ISR_OFF, 32'(s));
        idle(3);
        rd(`CISR_OFF, mid);
        src[s] <= rel;
        wr(`EOICR_OFF, xs());
        idle(3);
    endtask

    always @(posedge clock_in) begin
        rd_d <= bus.rd;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("MISMATCH run length expected end seen hang");
            conclude();
        end
    end

    always @(negedge clock_in) begin
        if (rd_d === 1'b1) begin
            n = notes.pop_front();
            check($sformatf("reg %h", n.addr), rdata, n.exp);
        end
    end

    initial begin
        int i, t, s;
        logic idl;
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        foreach (rst_regs[i]) rd(rst_regs[i], 32'h0);
        idle(2);
        $display("test reset values done");
        for (i = 0; i < 32; i++) begin
            vec[i] = xs();
            w = xs();
            wr(ofs(`SVR_BASE, i), vec[i]);
            wr(ofs(`SMR_BASE, i), w);
            rd(ofs(`SVR_BASE, i), vec[i]);
            rd(ofs(`SMR_BASE, i), w & 32'h0000_0067);
        end
        src <= 32'h0;
        wr(ofs(`SMR_BASE, 0), 32'h40);
        wr(ofs(`SMR_BASE, 30), 32'h40);
        wr(ofs(`SMR_BASE, 31), 32'h40);
        w = xs();
        en = xs();
        wr(`IECR_OFF, w);
        wr(`IECR_OFF, 32'h0);
        rd(`IMR_OFF, w);
        wr(`IDCR_OFF, en);
        wr(`IDCR_OFF, 32'h0);
        rd(`IMR_OFF, w & ~en);
        wr(`IDCR_OFF, 32'hffff_ffff);
        rd(`IMR_OFF, 32'h0);
        rd(`IPR_OFF, 32'h0);
        idle(2);
        $display("test registers done");
        ce <= 1'b0;
        wr(`SPU_OFF, 32'h5a5a_0f0f);
        ce <= 1'b1;
        rd(`SPU_OFF, 32'h0);
        wr(ofs(`SMR_BASE, 3), 32'h2);
        wr(ofs(`SMR_BASE, 5), 32'h6);
        wr(`IECR_OFF, 32'h28);
        src <= 32'h28;
        idle(4);
        rd(`IPR_OFF, 32'h28);
        rd(`CISR_OFF, 32'h2);
        service(5, 4'h0, 32'h0, 1'b0);
        service(3, 4'h9, 32'h0, 1'b0);
        rd(`IPR_OFF, 32'h0);
        wr(`IDCR_OFF, 32'h28);
        $display("test priority done");
        for (i = 0; i < 8; i++) begin
            s = (i < 4) ? 8 : 30;
            t = i % 4;
            idl = (s == 30 && t < 2);
            wr(ofs(`SMR_BASE, s), {25'h0, 2'(t), 5'h1});
            src[s] <= idl;
            idle(3);
            rd(`IPR_OFF, 32'h0);
            src[s] <= ~idl;
            idle(3);
            src[s] <= idl;
            idle(3);
            rd(`IPR_OFF, (t % 2 == 1) ? (32'h1 << s) : 32'h0);
            if (t % 2 == 1) begin
                wr(`IECR_OFF, 32'h1 << s);
                service(s, 4'(i), 32'h0, idl);
                wr(`IDCR_OFF, 32'h1 << s);
                rd(`IPR_OFF, 32'h0);
            end
        end
        $display("test triggers done");
        spur = xs();
        wr(`SPU_OFF, spur);
        wr(`EVT_MASK_OFF, 32'h1);
        rd(`IVR_OFF, spur);
        wr(`EOICR_OFF, 32'h0);
        idle(3);
        lines(3'b111);
        rd(`EVT_STAT_OFF, 32'h3);
        idle(3);
        lines(3'b011);
        wr(`EVT_MASK_OFF, 32'h0);
        rd(`FVR_OFF, spur);
        idle(3);
        lines(3'b011);
        rd(`EVT_STAT_OFF, 32'h4);
        $display("test spurious done");
        wr(ofs(`SMR_BASE, 0), 32'h47);
        wr(`IECR_OFF, 32'h1);
        src[0] <= 1'b1;
        idle(3);
        lines(3'b010);
        rd(`CISR_OFF, 32'h1);
        rd(`FVR_OFF, vec[0]);
        src[0] <= 1'b0;
        idle(3);
        lines(3'b011);
        wr(`IDCR_OFF, 32'h1);
        $display("test fast done");
        wr(`DCR_OFF, 32'h1);
        wr(ofs(`SMR_BASE, 4), 32'h3);
        wr(`IECR_OFF, 32'h10);
        src[4] <= 1'b1;
        idle(3);
        rd(`IVR_OFF, vec[4]);
        idle(3);
        lines(3'b001);
        wr(`IVR_OFF, xs());
        idle(3);
        rd(`ISR_OFF, 32'h4);
        lines(3'b011);
        wr(`EOICR_OFF, 32'h0);
        idle(3);
        lines(3'b001);
        wr(`DCR_OFF, 32'h2);
        idle(3);
        lines(3'b011);
        rd(`CISR_OFF, 32'h0);
        wr(`DCR_OFF, 32'h0);
        idle(3);
        lines(3'b001);
        service(4, 4'hc, 32'h0, 1'b0);
        $display("test protect and mask done");
        conclude();
    end
endmodule
`default_nettype wire
